// ==== design/xcc_regs.vh ====
// Notes on behaviour
// RL1 - power-down keeps cache memories unreachable; a flush write still walks and clears the tags
// RL2 - writing power-down forces cache enable low
// RL3 - sram access while powered down errors
// RL4 - non-zero alias write faults or drops
// RL5 - alias zero write invalidates matching line
// RL6 - disabled cache sends accesses to flash
// RL7 - enabled hit with valid line skips flash
// RL8 - sram access while enabled errors, untouched
// RL9 - flush write clears tags, keeps data
// RL10 - flush register read stalls until done
// RL11 - flush ready low while flushing only
// RL12 - reset release starts a full flush
// RL13 - two entry stream buffer, full/empty flags
// RL14 - saturating hit tally, write clears
// RL15 - saturating access tally, write clears
// RL16 - software loads pointer, hardware advances it
// RL17 - software may poll status instead
// RL18 - tallies hold at all ones
// RL19 - stream count runs down, zero aborts
// RL20 - flush bit self clears, zero ignored
`ifndef XCC_REGS_VH
`define XCC_REGS_VH
// register byte offsets
`define XCC_OFS_CONTROL   6'h00
`define XCC_OFS_FLUSH     6'h04
`define XCC_OFS_STATUS    6'h08
`define XCC_OFS_HIT       6'h0c
`define XCC_OFS_ACCESS    6'h10
`define XCC_OFS_POINTER   6'h14
`define XCC_OFS_STREAMCNT 6'h18
// control field positions
`define XCC_CTL_EN        0
`define XCC_CTL_BADWR     1
`define XCC_CTL_PDOWN     3
// flush field position
`define XCC_FLUSH_GO      0
// status field positions
`define XCC_ST_READY      0
`define XCC_ST_EMPTY      1
`define XCC_ST_FULL       2
// reset values
`define XCC_RST_EN        1'b1
`define XCC_RST_BADWR     1'b1
`define XCC_RST_PDOWN     1'b0
`define XCC_RST_TALLY     32'h00000000
`define XCC_RST_POINTER   30'h00000000
`define XCC_RST_STREAMCNT 22'h000000
// alias codes and bus answers
`define XCC_ALIAS_ALLOC   2'h0
`define XCC_RESP_OKAY     2'h0
`define XCC_RESP_SLVERR   2'h2
// pointer step per streamed word
`define XCC_PTR_STEP      30'h00000001
`endif

// ==== design/xcc_ctrl.v ====
`timescale 1ns/100ps
`default_nettype none
`include "xcc_regs.vh"
module xcc_ctrl #(
  parameter TAG_ENTRIES = 64,
  parameter TAG_AW      = 6,
  parameter CNT_W       = 22
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [5:0]        s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [5:0]        s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              xip_req,
  input  wire              xip_write,
  input  wire [1:0]        xip_alias,
  input  wire              xip_sram,
  input  wire              xip_tag_match,
  input  wire              xip_line_valid,
  output reg               xip_done,
  output reg               xip_err,
  output reg               xip_flash_read,
  output reg               xip_from_cache,
  output reg               xip_invalidate,
  output reg               xip_sram_ok,
  output reg               cache_power_down,
  output reg               cache_enable,
  output reg               tag_clear,
  output reg  [TAG_AW-1:0] tag_clear_index,
  output reg               stream_req,
  output reg  [31:0]       stream_addr,
  input  wire              stream_ack,
  input  wire [31:0]       stream_data,
  input  wire              fifo_pop,
  output reg  [31:0]       fifo_data,
  output reg               fifo_empty,
  output reg               fifo_full
);
  localparam [31:0]       LAST_TAG_W = TAG_ENTRIES - 1;
  localparam [TAG_AW-1:0] LAST_TAG   = LAST_TAG_W[TAG_AW-1:0]; // cut to index width on purpose
  // control and state registers
  reg              fault_on_bad_alias_write;
  reg              flush_busy;
  reg [31:0]       hit_tally;
  reg [31:0]       access_tally;
  reg [29:0]       stream_read_pointer;
  reg [CNT_W-1:0]  stream_count;
  reg              stream_discard;
  reg [31:0]       fifo_slot1;
  // bus holding state
  reg [5:0]        wr_addr;
  reg [31:0]       wr_data;
  reg              wr_addr_held;
  reg              wr_data_held;
  reg [5:0]        rd_addr;
  reg              rd_pend;
  // write strobe decode
  wire wr_fire = wr_addr_held && wr_data_held && !s_axi_bvalid;
  wire wr_ctl  = wr_fire && (wr_addr == `XCC_OFS_CONTROL);
  wire wr_fl   = wr_fire && (wr_addr == `XCC_OFS_FLUSH);
  wire wr_hit  = wr_fire && (wr_addr == `XCC_OFS_HIT);
  wire wr_acc  = wr_fire && (wr_addr == `XCC_OFS_ACCESS);
  wire wr_ptr  = wr_fire && (wr_addr == `XCC_OFS_POINTER);
  wire wr_cnt  = wr_fire && (wr_addr == `XCC_OFS_STREAMCNT);
  wire wr_map  = wr_ctl || wr_fl || wr_hit || wr_acc || wr_ptr || wr_cnt ||
                 (wr_fire && (wr_addr == `XCC_OFS_STATUS));
  // access classification for the cache side
  wire cacheable = !xip_alias[1];
  wire alloc_wr  = xip_write && (xip_alias == `XCC_ALIAS_ALLOC);
  wire line_hit  = cache_enable && cacheable && xip_tag_match && xip_line_valid;
  wire xip_read  = xip_req && !xip_sram && !xip_write;
  wire hit_evt   = xip_read && line_hit;
  wire acc_evt   = xip_req && !xip_sram;
  // stream buffer events
  wire do_pop    = fifo_pop && !fifo_empty;
  wire do_push   = stream_ack && stream_req && !stream_discard;

  // control register, power-down overrides enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      cache_enable             <= `XCC_RST_EN;
      fault_on_bad_alias_write <= `XCC_RST_BADWR;
      cache_power_down         <= `XCC_RST_PDOWN;
    end else if (wr_ctl) begin
      cache_power_down         <= wr_data[`XCC_CTL_PDOWN]; // [RL1]
      fault_on_bad_alias_write <= wr_data[`XCC_CTL_BADWR];
      cache_enable             <= wr_data[`XCC_CTL_EN] && !wr_data[`XCC_CTL_PDOWN]; // [RL2]
    end
  end

  // flush walker, armed by reset so the release starts a full clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      flush_busy      <= 1'b1; // [RL12]
      tag_clear       <= 1'b0;
      tag_clear_index <= {TAG_AW{1'b0}};
    end else if (wr_fl && wr_data[`XCC_FLUSH_GO]) begin
      flush_busy      <= 1'b1; // [RL9] [RL20]
      tag_clear       <= 1'b0;
      tag_clear_index <= {TAG_AW{1'b0}};
    end else if (flush_busy) begin
      tag_clear <= 1'b1; // tags only, data ram untouched [RL9]
      if (tag_clear) begin
        if (tag_clear_index == LAST_TAG) begin
          flush_busy <= 1'b0;
          tag_clear  <= 1'b0;
        end else begin
          tag_clear_index <= tag_clear_index + 1'b1;
        end
      end
    end
  end

  // per-access decisions, one cycle after the request
  always @(posedge aclk) begin
    if (!aresetn) begin
      xip_done       <= 1'b0;
      xip_err        <= 1'b0;
      xip_flash_read <= 1'b0;
      xip_from_cache <= 1'b0;
      xip_invalidate <= 1'b0;
      xip_sram_ok    <= 1'b0;
    end else begin
      xip_done       <= xip_req;
      xip_err        <= 1'b0;
      xip_flash_read <= 1'b0;
      xip_from_cache <= 1'b0;
      xip_invalidate <= 1'b0;
      xip_sram_ok    <= 1'b0;
      if (xip_req) begin
        if (xip_sram) begin
          if (cache_power_down || cache_enable)
            xip_err <= 1'b1; // [RL3] [RL8]
          else
            xip_sram_ok <= 1'b1;
        end else if (xip_write) begin
          if (alloc_wr)
            xip_invalidate <= xip_tag_match && !cache_power_down; // [RL5] [RL1]
          else
            xip_err <= fault_on_bad_alias_write; // [RL4]
        end else if (line_hit) begin
          xip_from_cache <= 1'b1; // [RL7]
        end else begin
          xip_flash_read <= 1'b1; // [RL6]
        end
      end
    end
  end

  // saturating tallies, an event in the clearing cycle still counts
  always @(posedge aclk) begin
    if (!aresetn) begin
      hit_tally    <= `XCC_RST_TALLY;
      access_tally <= `XCC_RST_TALLY;
    end else begin
      if (wr_hit)
        hit_tally <= {31'h00000000, hit_evt}; // [RL14]
      else if (hit_evt && (hit_tally != 32'hffffffff))
        hit_tally <= hit_tally + 32'h00000001; // [RL14] [RL18]
      if (wr_acc)
        access_tally <= {31'h00000000, acc_evt}; // [RL15]
      else if (acc_evt && (access_tally != 32'hffffffff))
        access_tally <= access_tally + 32'h00000001; // [RL15] [RL18]
    end
  end

  // stream engine: pointer, count and one outstanding flash read
  always @(posedge aclk) begin
    if (!aresetn) begin
      stream_read_pointer <= `XCC_RST_POINTER;
      stream_count        <= `XCC_RST_STREAMCNT;
      stream_req          <= 1'b0;
      stream_discard      <= 1'b0;
      stream_addr         <= 32'h00000000;
    end else begin
      if (stream_req && stream_ack) begin
        stream_req     <= 1'b0;
        stream_discard <= 1'b0;
      end
      if (wr_cnt) begin
        stream_count   <= wr_data[CNT_W-1:0];
        stream_discard <= stream_req && !stream_ack; // abort drops in-flight [RL19]
      end else if (do_push) begin
        stream_count        <= stream_count - 1'b1; // [RL19]
        stream_read_pointer <= stream_read_pointer + `XCC_PTR_STEP; // [RL16]
      end else if (wr_ptr) begin
        stream_read_pointer <= wr_data[31:2]; // [RL16]
      end
      // issue next read while room remains; only one read is ever in flight
      if (!stream_req && !wr_cnt && (stream_count != {CNT_W{1'b0}}) && !fifo_full) begin
        stream_req  <= 1'b1;
        stream_addr <= {stream_read_pointer, 2'b00};
      end
    end
  end

  // two entry stream buffer, head kept in its own flop
  always @(posedge aclk) begin
    if (!aresetn) begin
      fifo_data  <= 32'h00000000;
      fifo_slot1 <= 32'h00000000;
      fifo_empty <= 1'b1; // [RL13]
      fifo_full  <= 1'b0; // [RL13]
    end else begin
      if (do_pop && do_push) begin
        if (fifo_full) begin
          fifo_data  <= fifo_slot1;
          fifo_slot1 <= stream_data;
        end else begin
          fifo_data <= stream_data;
        end
      end else if (do_pop) begin
        fifo_data  <= fifo_slot1;
        fifo_full  <= 1'b0;
        fifo_empty <= !fifo_full;
      end else if (do_push && !fifo_full) begin
        if (fifo_empty)
          fifo_data <= stream_data;
        else
          fifo_slot1 <= stream_data;
        fifo_empty <= 1'b0;
        fifo_full  <= !fifo_empty; // [RL13]
      end
    end
  end

  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `XCC_RESP_OKAY;
      wr_addr_held  <= 1'b0;
      wr_data_held  <= 1'b0;
      wr_addr       <= 6'h00;
      wr_data       <= 32'h00000000;
    end else begin
      s_axi_awready <= !wr_addr_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wr_data_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr      <= {s_axi_awaddr[5:2], 2'b00};
        wr_addr_held <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data      <= s_axi_wdata;
        wr_data_held <= 1'b1;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `XCC_RESP_OKAY : `XCC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        wr_addr_held  <= 1'b0;
        wr_data_held  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel, flush register reads wait out a running flush
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `XCC_RESP_OKAY;
      rd_pend       <= 1'b0;
      rd_addr       <= 6'h00;
    end else begin
      s_axi_arready <= !rd_pend && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        rd_addr <= {s_axi_araddr[5:2], 2'b00};
        rd_pend <= 1'b1;
      end
      if (rd_pend && !((rd_addr == `XCC_OFS_FLUSH) && flush_busy)) begin // [RL10]
        rd_pend      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `XCC_RESP_OKAY;
        s_axi_rdata  <= 32'h00000000;
        if (rd_addr == `XCC_OFS_CONTROL)
          s_axi_rdata <= {28'h0000000, cache_power_down, 1'b0, fault_on_bad_alias_write, cache_enable};
        else if (rd_addr == `XCC_OFS_FLUSH)
          s_axi_rdata <= 32'h00000000; // bit self clears [RL20]
        else if (rd_addr == `XCC_OFS_STATUS)
          s_axi_rdata <= {29'h00000000, fifo_full, fifo_empty, !flush_busy}; // [RL11] [RL17]
        else if (rd_addr == `XCC_OFS_HIT)
          s_axi_rdata <= hit_tally;
        else if (rd_addr == `XCC_OFS_ACCESS)
          s_axi_rdata <= access_tally;
        else if (rd_addr == `XCC_OFS_POINTER)
          s_axi_rdata <= {stream_read_pointer, 2'b00};
        else if (rd_addr == `XCC_OFS_STREAMCNT)
          s_axi_rdata <= {{(32-CNT_W){1'b0}}, stream_count};
        else
          s_axi_rresp <= `XCC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/xcc_ctrl_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module xcc_ctrl_checker #(parameter TAG_AW = 6) (
  input wire logic              aclk, aresetn, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [5:0]        s_axi_araddr,
  input wire logic              xip_req, xip_write, xip_sram, xip_tag_match, xip_line_valid,
  input wire logic [1:0]        xip_alias,
  input wire logic              xip_err, xip_flash_read, xip_from_cache, xip_invalidate,
  input wire logic              cache_power_down, cache_enable, tag_clear,
  input wire logic [TAG_AW-1:0] tag_clear_index,
  input wire logic              stream_req, stream_ack, fifo_full, fifo_empty,
  input wire logic [31:0]       stream_addr
);
  logic rd_flush;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // remember whether the read in flight targets the flush register
  always @(posedge aclk) begin
    if (!aresetn)
      rd_flush <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      rd_flush <= s_axi_araddr[5:2] == 4'h1;
  end
  sequence s_rel; $rose(aresetn); endsequence
  sequence s_walk; tag_clear [*2]; endsequence
  sequence s_next; stream_req && stream_ack ##1 !stream_req ##1 stream_req; endsequence
  reset_flush_a: assert property (s_rel |-> ##[0:2] s_walk)
    else $error("no tag walk after reset");
  walk_step_a: assert property (s_walk |-> tag_clear_index == $past(tag_clear_index) + 1'b1 || tag_clear_index == '0)
    else $error("tag walk skipped an entry");
  flush_stall_a: assert property (s_axi_rvalid && rd_flush |-> !tag_clear)
    else $error("flush read answered during flush");
  pdown_en_a: assert property (cache_power_down |-> !cache_enable)
    else $error("enabled while powered down");
  hit_skip_a: assert property (xip_req && cache_enable && !xip_write && !xip_sram && !xip_alias[1]
    && xip_tag_match && xip_line_valid |=> xip_from_cache && !xip_flash_read) else $error("hit went to flash");
  bypass_a: assert property (xip_req && !cache_enable && !xip_write && !xip_sram |=> xip_flash_read && !xip_from_cache)
    else $error("disabled cache looked up");
  sram_err_a: assert property (xip_req && xip_sram && (cache_enable || cache_power_down) |=> xip_err)
    else $error("sram access not refused");
  alias_inval_a: assert property (xip_req && xip_write && !xip_sram && xip_alias == 2'h0 && xip_tag_match
    && !cache_power_down |=> xip_invalidate) else $error("matching line kept");
  req_hold_a: assert property (stream_req && !stream_ack |=> stream_req && $stable(stream_addr))
    else $error("stream request dropped");
  ptr_step_a: assert property (s_next |-> stream_addr == $past(stream_addr, 2) + 32'h4)
    else $error("pointer did not advance");
  full_stop_a: assert property (fifo_full |-> !stream_req && !fifo_empty)
    else $error("request while buffer full");
endmodule
bind xcc_ctrl xcc_ctrl_checker #(.TAG_AW(TAG_AW)) u_xcc_ctrl_checker (.*);
`default_nettype wire

// ==== tb/xcc_flash_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module xcc_flash_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        stream_req,
  input  wire logic [31:0] stream_addr,
  input  wire logic [1:0]  lag,
  output logic             stream_ack,
  output logic [31:0]      stream_data
);
  logic [1:0] waited;
  // answer a held read after lag cycles; the data line churns otherwise
  always @(posedge aclk) begin
    stream_data <= aresetn ? ~stream_data : 32'h0f0f0f0f;
    if (!aresetn || stream_ack || !stream_req) begin
      stream_ack <= 1'b0;
      waited <= 2'h0;
    end else if (waited == lag) begin
      stream_ack <= 1'b1;
      stream_data <= ~stream_addr;
    end else begin
      waited <= waited + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/xip_cache_control_regs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module xip_cache_control_regs_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, stream_addr, stream_data, fifo_data, p;
  logic [1:0]  s_axi_bresp, s_axi_rresp, xip_alias, lag;
  logic [2:0]  s_axi_awprot, s_axi_arprot, tag_clear_index;
  logic [3:0]  s_axi_wstrb;
  logic        xip_req, xip_write, xip_sram, xip_tag_match, xip_line_valid, xip_done, xip_err;
  logic        xip_flash_read, xip_from_cache, xip_invalidate, xip_sram_ok, cache_power_down;
  logic        cache_enable, tag_clear, stream_req, stream_ack, fifo_pop, fifo_empty, fifo_full;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  logic [4:0]  xq[$];
  logic [65:0] re;
  int          errors, tests_run, n;
  xcc_ctrl #(.TAG_ENTRIES(8), .TAG_AW(3)) u_xcc_ctrl (.*);
  xcc_flash_model u_xcc_flash_model (.*);
  // free running clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task final_report;
    $display("comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
    rq.push_back({r, m, e & m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask
  task automatic xa(input logic w, input logic [1:0] al, input logic s, t, v, input logic [4:0] e);
    xq.push_back(e);
    {xip_req, xip_write, xip_alias, xip_sram, xip_tag_match, xip_line_valid} <= {1'b1, w, al, s, t, v};
    @(posedge aclk);
  endtask
  task xidle;
    xip_req <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic pp(input logic [31:0] e);
    n = 0;
    while (fifo_empty && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk("fifo", fifo_data, e);
    fifo_pop <= 1'b1;
    @(posedge aclk);
    fifo_pop <= 1'b0;
    @(posedge aclk);
  endtask
  // compare each answer with the oldest expectation noted by its driver
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      chk("rdata", s_axi_rdata & re[63:32], re[31:0]);
      chk("rresp", 32'(s_axi_rresp), 32'(re[65:64]));
    end
    if (s_axi_bvalid && s_axi_bready) chk("bresp", 32'(s_axi_bresp), 32'(bq.pop_front()));
    if (xip_done) chk("xip", 32'({xip_err, xip_flash_read, xip_from_cache, xip_invalidate, xip_sram_ok}), 32'(xq.pop_front()));
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    final_report;
  end
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {xip_req, xip_write, xip_sram, xip_tag_match, xip_line_valid, fifo_pop, xip_alias} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot, lag} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1; // answers are always accepted at once
    s_axi_rready = 1'b1;
    n = $urandom(32'h83e9);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(6'h08, 32'h7, 32'h2, 2'h0);
    rd(6'h04, 32'h1, 32'h0, 2'h0);
    rd(6'h08, 32'h7, 32'h3, 2'h0);
    rd(6'h00, 32'hb, 32'h3, 2'h0);
    xa(0, 2'h0, 0, 1, 1, 5'b00100);
    xa(0, 2'h0, 0, 1, 0, 5'b01000);
    xa(0, 2'h2, 0, 1, 1, 5'b01000);
    xa(1, 2'h0, 0, 1, 0, 5'b00010);
    xa(1, 2'h1, 0, 0, 0, 5'b10000);
    xa(0, 2'h0, 1, 0, 0, 5'b10000);
    xidle;
    rd(6'h0c, '1, 32'h1, 2'h0);
    rd(6'h10, '1, 32'h5, 2'h0);
    wr(6'h0c, $urandom, 2'h0);
    wr(6'h10, $urandom, 2'h0);
    rd(6'h0c, '1, 32'h0, 2'h0);
    rd(6'h10, '1, 32'h0, 2'h0);
    wr(6'h00, 32'h1, 2'h0);
    xa(1, 2'h3, 0, 0, 0, 5'b00000);
    xa(1, 2'h0, 0, 1, 1, 5'b00010);
    xidle;
    wr(6'h00, 32'h0, 2'h0);
    xa(0, 2'h0, 0, 1, 1, 5'b01000);
    xa(0, 2'h0, 1, 0, 0, 5'b00001);
    xidle;
    wr(6'h00, 32'h9, 2'h0);
    rd(6'h00, 32'hb, 32'h8, 2'h0);
    xa(0, 2'h0, 1, 0, 0, 5'b10000);
    xa(1, 2'h0, 0, 1, 1, 5'b00000);
    xidle;
    wr(6'h04, 32'h1, 2'h0);
    rd(6'h08, 32'h1, 32'h0, 2'h0);
    rd(6'h04, 32'h1, 32'h0, 2'h0);
    wr(6'h04, 32'h0, 2'h0);
    wr(6'h08, '1, 2'h0);
    rd(6'h08, 32'h7, 32'h3, 2'h0);
    rd(6'h1c, 32'h0, 32'h0, 2'h2);
    wr(6'h1c, 32'h1, 2'h2);
    p = $urandom & 32'h00fffffc;
    lag = 2'($urandom);
    wr(6'h14, p, 2'h0);
    rd(6'h14, 32'hfffffffc, p, 2'h0);
    wr(6'h18, 32'h3, 2'h0);
    n = 0;
    while (!fifo_full && n < 100) begin
      @(posedge aclk);
      n++;
    end
    rd(6'h08, 32'h7, 32'h5, 2'h0);
    rd(6'h14, 32'hfffffffc, p + 32'h8, 2'h0);
    pp(~p);
    pp(~(p + 32'h4));
    pp(~(p + 32'h8));
    rd(6'h18, '1, 32'h0, 2'h0);
    rd(6'h14, 32'hfffffffc, p + 32'hc, 2'h0);
    final_report;
  end
endmodule
`default_nettype wire
